// ### verilog/sfp_ctrl_pkg.sv
// constants and types shared by the transceiver management logic
package sfp_ctrl_pkg;
  // two-wire device addresses, upper seven bits of the address byte
  localparam logic [6:0] ID_DEV_ADDR   = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  // diagnostic space layout
  localparam logic [7:0] STATUS_CTRL_OFFSET = 8'h6E;
  localparam logic [7:0] DIAG_FIRST_OFFSET  = 8'h60;
  localparam logic [7:0] DIAG_LAST_OFFSET   = 8'h69;
  localparam int         STAT_DIS_PIN_BIT   = 7;
  localparam int         STAT_SOFT_DIS_BIT  = 6;
  localparam int         STAT_FAULT_BIT     = 2;
  localparam int         STAT_LOS_BIT       = 1;
  localparam logic       SOFT_DIS_RESET     = 1'b0;
  localparam int         DIAG_VALUES        = 5;
  localparam int         DIAG_WIDTH         = 16;
  // serial framing
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam int         SYNC_DEPTH = 3;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DEV   = 5'b00010,
    ST_ADDR  = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_READ  = 5'b10000
  } link_state_type;
endpackage

// ### verilog/sfp_module_control_status.sv
// transceiver control, fault latch, loss-of-signal and serial management
`timescale 1ns/100ps
module sfp_module_control_status
  import sfp_ctrl_pkg::*;
#(
  parameter int DIAG_ENABLE = 1
) (
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  RST_I,
  input  wire logic                  TX_DISABLE_I,
  input  wire logic                  LASER_FAULT_I,
  input  wire logic                  SUPPLY_LOW_I,
  input  wire logic                  SIGNAL_POOR_I,
  input  wire logic [DIAG_WIDTH-1:0] TEMP_I,
  input  wire logic [DIAG_WIDTH-1:0] SUPPLY_VOLT_I,
  input  wire logic [DIAG_WIDTH-1:0] BIAS_I,
  input  wire logic [DIAG_WIDTH-1:0] TX_POWER_I,
  input  wire logic [DIAG_WIDTH-1:0] RX_POWER_I,
  input  wire logic                  SCL_I,
  input  wire logic                  SDA_I,
  output wire logic                  SDA_O,
  output wire logic                  SDA_OE_O,
  output wire logic                  LASER_ON_O,
  output wire logic                  TX_FAULT_O,
  output wire logic                  TX_FAULT_OE_O,
  output wire logic                  SIGNAL_LOST_OUTPUT_O
);

  if (DIAG_ENABLE != 0 && DIAG_ENABLE != 1) begin : g_chk
    $error("DIAG_ENABLE must be 0 or 1");
  end

  localparam int IN_DIS  = 0;
  localparam int IN_LF   = 1;
  localparam int IN_LOW  = 2;
  localparam int IN_POOR = 3;
  localparam int IN_SOFT = 4;
  localparam int IN_HOLD = 5;
  localparam int L_DIS   = 0;
  localparam int L_FAULT = 1;
  localparam int L_LOS   = 2;

  typedef logic [DIAG_VALUES-1:0][DIAG_WIDTH-1:0] diag_type;

  typedef struct packed {
    logic [5:0][SYNC_DEPTH-1:0] sync;
    logic [5:0]                 filt;
    logic                       dis_prev;
    logic                       fault_latched;
    logic                       fault_flag;
    logic                       fault_oe;
    logic                       laser_on;
    logic                       signal_lost;
    diag_type                   snap;
  } sys_state_type;

  typedef struct packed {
    link_state_type             st;
    logic [3:0]                 cnt;
    logic [7:0]                 shreg;
    logic [7:0]                 tx;
    logic [7:0]                 ptr;
    logic                       sel;
    logic                       ack;
    logic                       soft_dis;
    logic                       hold;
    logic                       tog_seen;
    logic [2:0][SYNC_DEPTH-1:0] sync;
    logic [2:0]                 filt;
  } link_state_type_s_type;

  // three-stage pin synchroniser; a change counts once stages 2 and 3 agree
  function automatic logic [SYNC_DEPTH:0] sync_step(
    input logic [SYNC_DEPTH-1:0] chain,
    input logic                  din,
    input logic                  filt
  );
    logic nf;
    nf = (chain[SYNC_DEPTH-1] == chain[SYNC_DEPTH-2]) ?
         chain[SYNC_DEPTH-1] : filt;
    return {nf, chain[SYNC_DEPTH-2:0], din};
  endfunction

  // byte seen by the host at an address of the selected space
  function automatic logic [7:0] read_byte(
    input logic       sel,
    input logic [7:0] addr,
    input logic [7:0] stored,
    input diag_type   snap,
    input logic [7:0] status
  );
    logic [7:0]            off;
    logic [DIAG_WIDTH-1:0] w;
    off = addr - DIAG_FIRST_OFFSET;
    w   = snap[off[3:1]];
    if (!sel) begin
      return stored;
    end else if (addr == STATUS_CTRL_OFFSET) begin
      return status;
    end else if (addr >= DIAG_FIRST_OFFSET && addr <= DIAG_LAST_OFFSET) begin
      return off[0] ? w[7:0] : w[15:8];
    end else begin
      return stored;
    end
  endfunction

  sys_state_type         s;
  sys_state_type         next_s;
  link_state_type_s_type l;
  link_state_type_s_type next_l;
  logic [5:0]            din;
  logic                  dis_rise;
  logic                  start_tog;
  logic                  start;
  logic [7:0]            byte_in;
  logic [7:0]            ptr_inc;
  logic [7:0]            status;
  logic                  wr_en;
  logic                  sda_drive;
  logic [7:0]            mem [0:511];

  // ---------------- system clock domain ----------------
  assign din = {l.hold, l.soft_dis, SIGNAL_POOR_I, SUPPLY_LOW_I,
                LASER_FAULT_I, TX_DISABLE_I};
  assign dis_rise = s.filt[IN_DIS] && !s.dis_prev;

  always_comb begin
    next_s = s;
    for (int i = 0; i < 6; i++) begin
      {next_s.filt[i], next_s.sync[i]} = sync_step(s.sync[i], din[i],
                                                   s.filt[i]);
    end
    next_s.dis_prev = s.filt[IN_DIS];
    // set wins over the clearing toggle
    next_s.fault_latched = (s.fault_latched && !dis_rise) ||
                           s.filt[IN_LF];
    // supply dip follows the condition, no latch
    next_s.fault_flag = next_s.fault_latched || s.filt[IN_LOW];
    next_s.fault_oe = !next_s.fault_flag;
    next_s.laser_on = !s.filt[IN_DIS] && !s.filt[IN_SOFT] &&
                      !next_s.fault_flag;
    next_s.signal_lost = s.filt[IN_POOR];
    // monitor values freeze while the link reads them
    if (!s.filt[IN_HOLD]) begin
      next_s.snap = {RX_POWER_I, TX_POWER_I, BIAS_I, SUPPLY_VOLT_I,
                     TEMP_I};
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign LASER_ON_O           = s.laser_on;
  assign TX_FAULT_O           = 1'b0;
  assign TX_FAULT_OE_O        = s.fault_oe;
  assign SIGNAL_LOST_OUTPUT_O = s.signal_lost;

  // ---------------- link clock domain ----------------
  // start: data falls while clock is high; seen at the next clock rise
  always_ff @(negedge SDA_I or posedge RST_I) begin
    if (RST_I) begin
      start_tog <= 1'b0;
    end else if (SCL_I) begin
      start_tog <= ~start_tog;
    end
  end

  assign start   = start_tog != l.tog_seen;
  assign byte_in = {l.shreg[6:0], SDA_I};
  assign ptr_inc = l.ptr + 8'h01;

  always_comb begin
    status = 8'h00;
    status[STAT_DIS_PIN_BIT]  = l.filt[L_DIS];
    status[STAT_SOFT_DIS_BIT] = l.soft_dis;
    status[STAT_FAULT_BIT]    = l.filt[L_FAULT];
    status[STAT_LOS_BIT]      = l.filt[L_LOS];
  end

  always_comb begin
    next_l = l;
    wr_en  = 1'b0;
    for (int i = 0; i < 3; i++) begin
      {next_l.filt[i], next_l.sync[i]} = sync_step(l.sync[i],
        (i == L_DIS) ? s.filt[IN_DIS] :
        (i == L_FAULT) ? s.fault_flag : s.signal_lost, l.filt[i]);
    end
    if (start) begin
      next_l.tog_seen = start_tog;
      next_l.st       = ST_DEV;
      next_l.shreg    = {7'h00, SDA_I};
      next_l.cnt      = 4'h1;
      next_l.ack      = 1'b0;
      next_l.hold     = 1'b1;
    end else begin
      case (l.st)
        ST_DEV, ST_ADDR, ST_WRITE: begin
          if (l.cnt == ACK_SLOT) begin
            next_l.cnt = 4'h0;
            next_l.ack = 1'b0;
            if (!l.ack) begin
              next_l.st   = ST_IDLE;
              next_l.hold = 1'b0;
            end else if (l.st == ST_DEV && l.shreg[0]) begin
              next_l.st = ST_READ;
              next_l.tx = read_byte(l.sel, l.ptr, mem[{l.sel, l.ptr}],
                                    s.snap, status);
            end else if (l.st == ST_DEV) begin
              next_l.st = ST_ADDR;
            end else begin
              next_l.st   = ST_WRITE;
              next_l.hold = 1'b0;
            end
          end else begin
            next_l.shreg = byte_in;
            next_l.cnt   = l.cnt + 4'h1;
            if (l.cnt == LAST_BIT) begin
              case (l.st)
                ST_DEV: begin
                  next_l.sel = byte_in[1];
                  next_l.ack = (byte_in[7:1] == ID_DEV_ADDR) ||
                               (DIAG_ENABLE == 1 &&
                                byte_in[7:1] == DIAG_DEV_ADDR);
                end
                ST_ADDR: begin
                  next_l.ptr = byte_in;
                  next_l.ack = 1'b1;
                end
                default: begin
                  wr_en      = 1'b1;
                  next_l.ptr = ptr_inc;
                  next_l.ack = 1'b1;
                  if (l.sel && l.ptr == STATUS_CTRL_OFFSET) begin
                    next_l.soft_dis = byte_in[STAT_SOFT_DIS_BIT];
                  end
                end
              endcase
            end
          end
        end
        ST_READ: begin
          if (l.cnt == ACK_SLOT) begin
            next_l.cnt = 4'h0;
            next_l.ptr = ptr_inc;
            next_l.tx  = read_byte(l.sel, ptr_inc,
                                   mem[{l.sel, ptr_inc}], s.snap,
                                   status);
            if (SDA_I) begin
              next_l.st   = ST_IDLE;
              next_l.hold = 1'b0;
            end
          end else begin
            next_l.tx  = {l.tx[6:0], 1'b0};
            next_l.cnt = l.cnt + 4'h1;
          end
        end
        ST_IDLE: begin
          next_l.cnt = 4'h0;
        end
        default: begin
          next_l.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SCL_I or posedge RST_I) begin
    if (RST_I) begin
      l          <= '0;
      l.st       <= ST_IDLE;
      l.soft_dis <= SOFT_DIS_RESET;
    end else begin
      l <= next_l;
    end
  end

  // identification and user bytes; not reset, like the EEPROM it stands for
  always_ff @(posedge SCL_I) begin
    if (wr_en) begin
      mem[{l.sel, l.ptr}] <= byte_in;
    end
  end

  // data changes only while the clock is low
  always_ff @(negedge SCL_I or posedge RST_I) begin
    if (RST_I) begin
      sda_drive <= 1'b0;
    end else begin
      sda_drive <= (l.st != ST_READ && l.st != ST_IDLE &&
                    l.cnt == ACK_SLOT && l.ack) ||
                   (l.st == ST_READ && l.cnt <= LAST_BIT && !l.tx[7]);
    end
  end

  assign SDA_O    = 1'b0;
  assign SDA_OE_O = sda_drive;

  // ---------------- checks ----------------
  sequence dis_toggle_seq;
    !s.filt[IN_DIS] ##1 s.filt[IN_DIS];
  endsequence

  pin_disable_off_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s.filt[IN_DIS] |=> !LASER_ON_O) else $error("laser on while disabled");
  toggle_clears_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    dis_toggle_seq ##0 !s.filt[IN_LF] |=> !s.fault_latched)
    else $error("toggle did not clear fault");
  fault_shutdown_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s.filt[IN_LF] |=> s.fault_flag && !LASER_ON_O)
    else $error("fault did not shut laser");
  fault_pin_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s.filt[IN_LOW] |=> !TX_FAULT_OE_O) else $error("fault pin held low");
  fault_latch_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s.fault_latched && !dis_rise |=> s.fault_latched)
    else $error("fault latch lost");
  supply_release_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !s.filt[IN_LF] && !s.fault_latched && !s.filt[IN_LOW] |=> !s.fault_flag)
    else $error("supply fault held");
  hw_fault_only_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $rose(s.fault_flag) |-> $past(s.filt[IN_LF] || s.filt[IN_LOW]))
    else $error("fault without cause");
  signal_lost_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s.filt[IN_POOR] |=> SIGNAL_LOST_OUTPUT_O)
    else $error("loss of signal not shown");
  snap_frozen_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    s.filt[IN_HOLD] ##1 s.filt[IN_HOLD] |-> $stable(s.snap))
    else $error("monitor values moved");
  soft_disable_a: assert property (@(posedge SCL_I) disable iff (RST_I)
    !start && l.st == ST_WRITE && l.cnt == LAST_BIT && l.sel &&
    l.ptr == STATUS_CTRL_OFFSET |=>
    l.soft_dis == $past(byte_in[STAT_SOFT_DIS_BIT]))
    else $error("soft disable not stored");
  id_address_a: assert property (@(posedge SCL_I) disable iff (RST_I)
    !start && l.st == ST_DEV && l.cnt == LAST_BIT &&
    byte_in[7:1] == ID_DEV_ADDR |=> l.ack ##1 (l.st != ST_IDLE))
    else $error("id address not acknowledged");
  auto_inc_a: assert property (@(posedge SCL_I) disable iff (RST_I)
    !start && l.st == ST_READ && l.cnt == ACK_SLOT
    |=> l.ptr == $past(l.ptr) + 8'h01)
    else $error("address did not advance");

endmodule

// ### tb/sfp_host_model.sv
// host controller model driving the two-wire management bus
`timescale 1ns/100ps
module sfp_host_model (
  output logic      scl_o,
  output logic      sda_drv_o,
  input  wire logic sda_line_i
);
  localparam realtime QTR = 31.25;

  // bus idles high so the clock stands still between frames
  initial begin
    scl_o     = 1'b1;
    sda_drv_o = 1'b1;
  end

  task automatic start();
    #(QTR) sda_drv_o = 1'b1;
    #(QTR) scl_o = 1'b1;
    #(QTR) sda_drv_o = 1'b0;
    #(QTR) scl_o = 1'b0;
  endtask

  task automatic stop();
    #(QTR) sda_drv_o = 1'b0;
    #(QTR) scl_o = 1'b1;
    #(QTR) sda_drv_o = 1'b1;
    #(QTR);
  endtask

  // data moves only while the clock is low, away from either edge
  task automatic bit_io(input logic b, output logic r);
    #(QTR) sda_drv_o = b;
    #(QTR) scl_o = 1'b1;
    #(QTR) r = sda_line_i;
    #(QTR) scl_o = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ### tb/sfp_module_control_status_tb.sv
// self-checking bench for the transceiver control and management block
`timescale 1ns/100ps
module sfp_module_control_status_tb;
  import sfp_ctrl_pkg::*;
  typedef struct packed {
    logic [3:0] pins;
    logic [2:0] outs;
  } row_type;
  // pins {disable, laser fault, low supply, poor signal}
  // outs {laser on, fault line, loss of signal}
  row_type rows [6] = '{'{4'h0, 3'h4}, '{4'h8, 3'h0}, '{4'h2, 3'h2},
                        '{4'h0, 3'h4}, '{4'h1, 3'h5}, '{4'h0, 3'h4}};
  logic [DIAG_WIDTH-1:0] mon [DIAG_VALUES] =
    '{16'h1234, 16'h2345, 16'h3456, 16'h4567, 16'h5678};
  logic                  clk, rst, dis, lf, sl, sp, scl, sda_drv, k;
  logic                  sda_oe, laser, fault_oe, los;
  logic                  sda_o, fault_o;
  logic [2:0]            outs;
  logic [15:0]           v;
  int                    miscompares, checked, cycles;
  wire                   sda_line = sda_drv & ~sda_oe;

  // the fault line has a host pull-up; the module only pulls it low
  assign outs = {laser, ~fault_oe, los};

  sfp_module_control_status sfp_module_control_status_inst (
    .CLK_SYS_I(clk), .RST_I(rst), .TX_DISABLE_I(dis),
    .LASER_FAULT_I(lf), .SUPPLY_LOW_I(sl), .SIGNAL_POOR_I(sp),
    .TEMP_I(mon[0]), .SUPPLY_VOLT_I(mon[1]), .BIAS_I(mon[2]),
    .TX_POWER_I(mon[3]), .RX_POWER_I(mon[4]),
    .SCL_I(scl), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .LASER_ON_O(laser), .TX_FAULT_O(fault_o), .TX_FAULT_OE_O(fault_oe),
    .SIGNAL_LOST_OUTPUT_O(los));

  sfp_host_model host_inst (
    .scl_o(scl), .sda_drv_o(sda_drv), .sda_line_i(sda_line));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("[FAIL] %0t run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // eight clocks covers the three-stage synchroniser and output register
  task automatic pins(input logic [3:0] p);
    @(negedge clk);
    {dis, lf, sl, sp} = p;
    repeat (8) @(negedge clk);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] a,
                    input logic [7:0] d);
    host_inst.start();
    host_inst.send({dev, 1'b0}, k);
    check(16'(k), 16'h0001, "device ack on write");
    host_inst.send(a, k);
    host_inst.send(d, k);
    host_inst.stop();
  endtask

  task automatic rd(input logic [6:0] dev, input logic [7:0] a,
                    output logic [15:0] r);
    logic [7:0] h, l;
    host_inst.start();
    host_inst.send({dev, 1'b0}, k);
    host_inst.send(a, k);
    host_inst.start();
    host_inst.send({dev, 1'b1}, k);
    host_inst.recv(1'b0, h);
    host_inst.recv(1'b1, l);
    host_inst.stop();
    r = {h, l};
  endtask

  initial begin
    rst = 1'b1;
    {dis, lf, sl, sp} = 4'h0;
    repeat (2) @(posedge clk);
    #1;
    check(16'({outs, sda_oe}), 16'h0004, "reset outputs");
    @(negedge clk);
    rst = 1'b0;
    #1000;
    foreach (rows[i]) begin
      pins(rows[i].pins);
      check(16'(outs), 16'(rows[i].outs), "pin row");
    end
    pins(4'h4);
    check(16'(outs), 16'h0002, "laser fault");
    pins(4'h1);
    check(16'(outs), 16'h0003, "fault latch");
    rd(DIAG_DEV_ADDR, STATUS_CTRL_OFFSET, v);
    check(16'(v[15:8] & 8'hC6), 16'h0006, "status fault");
    pins(4'h9);
    check(16'(outs), 16'h0001, "latch clear");
    pins(4'h0);
    check(16'(outs), 16'h0004, "restart");
    wr(DIAG_DEV_ADDR, STATUS_CTRL_OFFSET, 8'h40);
    pins(4'h0);
    check(16'(outs), 16'h0000, "soft disable");
    pins(4'h8);
    rd(DIAG_DEV_ADDR, STATUS_CTRL_OFFSET, v);
    check(16'(v[15:8] & 8'hC6), 16'h00C0, "status disable");
    wr(DIAG_DEV_ADDR, STATUS_CTRL_OFFSET, 8'h00);
    pins(4'h0);
    check(16'(outs), 16'h0004, "soft enable");
    for (int m = 0; m < DIAG_VALUES; m++) begin
      rd(DIAG_DEV_ADDR, DIAG_FIRST_OFFSET + 8'(2 * m), v);
      check(v, mon[m], "monitor value");
    end
    wr(ID_DEV_ADDR, 8'h10, 8'h5A);
    wr(ID_DEV_ADDR, 8'h11, 8'hA5);
    rd(ID_DEV_ADDR, 8'h10, v);
    check(v, 16'h5AA5, "id memory");
    wr(DIAG_DEV_ADDR, 8'hFF, 8'h3C);
    wr(DIAG_DEV_ADDR, 8'h00, 8'hC3);
    rd(DIAG_DEV_ADDR, 8'hFF, v);
    check(v, 16'h3CC3, "diag memory wrap");
    // an unknown address must be ignored until the next start
    host_inst.start();
    host_inst.send({7'h33, 1'b0}, k);
    host_inst.stop();
    check(16'(k), 16'h0000, "foreign address");
    // open-drain pins only ever pull low
    check(16'({sda_o, fault_o}), 16'h0000, "open drain");
    // a latched fault is also cleared by a power cycle
    pins(4'h4);
    rst = 1'b1;
    {dis, lf, sl, sp} = 4'h0;
    repeat (2) @(negedge clk);
    check(16'(outs), 16'h0002, "reset again");
    rst = 1'b0;
    pins(4'h0);
    check(16'(outs), 16'h0004, "power cycle clear");
    tally_and_finish();
  end
endmodule
